// >>> hvpc_map.vh
// Constants for the high-voltage pin control block
//
// Summary of operation
// RQ1: Eight pins, two banks of four
// RQ2: Code 000 keeps pin off, ignores fields
// RQ3: Activation selects on, off or timer
// RQ4: Timer pulses switch configured output drivers
// RQ5: Low-side drivers only on in Normal mode
// RQ6: Disabled wake input is never sampled
// RQ7: Enabled wake input sampled at fixed rate
// RQ8: Timer wake input sampled at pulse end
// RQ9: Per-bank wake threshold: ground or ratiometric
// RQ10: Wake level status holds last sample
// RQ11: Enabled edge wake interrupts on level change
// RQ12: Function code selects slope control
// RQ13: Slope ramp first, full-on after delay
// RQ14: Direct control: 110 inverted, 111 straight
// RQ15: Bank-0 pin n follows pin n+4
// RQ16: Controller needs input configuration, not activation
// RQ17: Each direct pair enabled independently
// RQ18: No direct control on limp-home pins
// RQ19: Each timer has its own activation code
`ifndef HVPC_MAP_VH
`define HVPC_MAP_VH

`define HVPC_NPIN          8
`define HVPC_BANK_PINS     4

// Function configuration codes
`define HVPC_CC_OFF        3'h0
`define HVPC_CC_HS         3'h1
`define HVPC_CC_HS_SLOPE   3'h2
`define HVPC_CC_LS         3'h3
`define HVPC_CC_LS_SLOPE   3'h4
`define HVPC_CC_WAKE       3'h5
`define HVPC_CC_HS_WAKE    3'h6
`define HVPC_CC_HSS_WAKE   3'h7

// Activation control codes
`define HVPC_AC_DISABLED   3'h0
`define HVPC_AC_ENABLED    3'h1
`define HVPC_AC_TIMER1     3'h2
`define HVPC_AC_TIMER2     3'h3
`define HVPC_AC_TIMER3     3'h4
`define HVPC_AC_TIMER4     3'h5
`define HVPC_AC_DIRECT_INV 3'h6
`define HVPC_AC_DIRECT     3'h7

// Threshold selection
`define HVPC_THR_GND       1'b0
`define HVPC_THR_RATIO     1'b1

// Timing
`define HVPC_CLK_KHZ       10000
`define HVPC_T_DON_NS      10000
`define HVPC_DON_CYC       ((`HVPC_T_DON_NS * `HVPC_CLK_KHZ + 999999) / 1000000)
`define HVPC_T_WAKE_US     1000
`define HVPC_WAKE_CYC      ((`HVPC_T_WAKE_US * `HVPC_CLK_KHZ) / 1000)

`endif

// >>> hvpc_tick_gen.v
// Periodic wake sampling tick generator
`timescale 1ns/100ps
`include "hvpc_map.vh"

module hvpc_tick_gen #(
    parameter PERIOD = `HVPC_WAKE_CYC
) (
    input  wire i_clk,
    input  wire i_rst_n,
    output reg  o_tick
);
    localparam integer LAST_I = PERIOD - 1;
    localparam [23:0]  LAST   = LAST_I[23:0];
    reg [23:0] cnt_r;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_r  <= 24'h000000;
            o_tick <= 1'b0;
        end else if (cnt_r >= LAST) begin
            cnt_r  <= 24'h000000;
            o_tick <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 24'h000001;
            o_tick <= 1'b0;
        end
    end
endmodule

// >>> hvpc_slope_delay.v
// Per-pin slope ramp phase and full-on delay
`timescale 1ns/100ps
`include "hvpc_map.vh"

module hvpc_slope_delay (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_on,
    input  wire i_slope_en,
    output reg  o_ramp,
    output reg  o_full
);
    localparam integer DON_I = `HVPC_DON_CYC;
    localparam [7:0]   DON   = DON_I[7:0];
    reg [7:0] cnt_r;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_r  <= 8'h00;
            o_ramp <= 1'b0;
            o_full <= 1'b0;
        end else if (!i_on) begin
            cnt_r  <= 8'h00;
            o_ramp <= 1'b0;
            o_full <= 1'b0;
        end else if (!i_slope_en) begin
            o_ramp <= 1'b0;
            o_full <= 1'b1;
        end else if (cnt_r < DON) begin
            cnt_r  <= cnt_r + 8'h01;
            o_ramp <= 1'b1;
            o_full <= 1'b0;                                  // see RQ13
        end else begin
            o_ramp <= 1'b0;
            o_full <= 1'b1;                                  // see RQ13
        end
    end
endmodule

// >>> hvpc_top.v
// High-voltage pin control: function, activation, wake sampling, direct control
`timescale 1ns/100ps
`include "hvpc_map.vh"

module hvpc_top #(
    parameter WAKE_CYC = `HVPC_WAKE_CYC
) (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_eight_pins,
    input  wire        i_normal_mode,
    input  wire [23:0] i_pin_function_config,
    input  wire [23:0] i_pin_activation_control,
    input  wire        i_bank0_wake_threshold_sel,
    input  wire        i_bank1_wake_threshold_sel,
    input  wire [7:0]  i_level_above_gnd_thr,
    input  wire [7:0]  i_level_above_ratio_thr,
    input  wire [3:0]  i_timer_pulse,
    input  wire [2:0]  i_limp_home_cfg,
    input  wire [7:0]  i_rise_irq_en,
    input  wire [7:0]  i_fall_irq_en,
    output wire [7:0]  o_hs_drive,
    output wire [7:0]  o_ls_drive,
    output wire [7:0]  o_slope_ramp,
    output wire [7:0]  o_full_on,
    output wire [7:0]  o_input_en,
    output wire [7:0]  o_pin_wake_level_status,
    output wire [7:0]  o_rising_edge_wake_irq,
    output wire [7:0]  o_falling_edge_wake_irq
);
    reg  [3:0] timer_prev_r;
    wire [3:0] timer_fall;
    wire       wake_tick;
    wire [7:0] level;
    wire [7:0] drv_on;
    wire [7:0] slope_en;
    wire [7:0] sample_ev;

    assign timer_fall = timer_prev_r & ~i_timer_pulse;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            timer_prev_r <= 4'h0;
        end else begin
            timer_prev_r <= i_timer_pulse;
        end
    end

    hvpc_tick_gen #(
        .PERIOD (WAKE_CYC)
    ) u_tick (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_tick  (wake_tick)
    );

    genvar g;
    generate
        for (g = 0; g < `HVPC_NPIN; g = g + 1) begin : g_pin
            wire [2:0] cc;
            wire [2:0] ac;
            wire       thr;
            wire       present;
            wire       is_hs;
            wire       is_ls;
            wire       is_in;
            wire       act_timer;
            wire [1:0] tsel;
            wire       t_lvl;
            wire       direct_ok;
            wire       src_lvl;
            reg        want;
            reg        hs_r;
            reg        ls_r;
            reg        inen_r;
            reg        stat_r;
            reg        rise_r;
            reg        fall_r;
            reg        smp_r;

            // Each pin owns its flip-flops; the output buses are plain wires
            assign o_hs_drive[g]              = hs_r;
            assign o_ls_drive[g]              = ls_r;
            assign o_input_en[g]              = inen_r;
            assign o_pin_wake_level_status[g] = stat_r;
            assign o_rising_edge_wake_irq[g]  = rise_r;
            assign o_falling_edge_wake_irq[g] = fall_r;

            assign cc        = i_pin_function_config[g*3 +: 3];
            assign ac        = i_pin_activation_control[g*3 +: 3];
            assign present   = (g < `HVPC_BANK_PINS) || i_eight_pins;                   // see RQ1
            assign thr       = (g < `HVPC_BANK_PINS) ? i_bank0_wake_threshold_sel
                                                     : i_bank1_wake_threshold_sel;     // see RQ9
            assign level[g]  = (thr == `HVPC_THR_RATIO) ? i_level_above_ratio_thr[g]
                                                        : i_level_above_gnd_thr[g];    // see RQ9
            assign is_hs     = (cc == `HVPC_CC_HS) || (cc == `HVPC_CC_HS_SLOPE) ||
                               (cc == `HVPC_CC_HS_WAKE) || (cc == `HVPC_CC_HSS_WAKE);
            assign is_ls     = (cc == `HVPC_CC_LS) || (cc == `HVPC_CC_LS_SLOPE);
            assign is_in     = (cc == `HVPC_CC_WAKE) || (cc == `HVPC_CC_HS_WAKE) ||
                               (cc == `HVPC_CC_HSS_WAKE);
            assign slope_en[g] = (cc == `HVPC_CC_HS_SLOPE) || (cc == `HVPC_CC_LS_SLOPE) ||
                                 (cc == `HVPC_CC_HSS_WAKE);                              // see RQ12
            assign act_timer = (ac >= `HVPC_AC_TIMER1) && (ac <= `HVPC_AC_TIMER4);      // see RQ19
            assign tsel      = ac[1:0] - 2'h2;                                         // see RQ19
            assign t_lvl     = i_timer_pulse[tsel];

            if (g < `HVPC_BANK_PINS) begin : g_direct
                wire [2:0] src_cc;
                wire       limp;
                assign src_cc = i_pin_function_config[(g+4)*3 +: 3];
                if (g == 0) begin : g_nolimp
                    assign limp = 1'b0;
                end else begin : g_limp
                    assign limp = i_limp_home_cfg[g-1];                                 // see RQ18
                end
                assign src_lvl = level[g+4];                                            // see RQ15
                assign direct_ok = i_eight_pins && !limp &&
                                   ((src_cc == `HVPC_CC_WAKE) || (src_cc == `HVPC_CC_HS_WAKE) ||
                                    (src_cc == `HVPC_CC_HSS_WAKE));                     // see RQ16
            end else begin : g_nodirect
                assign src_lvl   = 1'b0;
                assign direct_ok = 1'b0;
            end

            always @* begin
                want = 1'b0;
                case (ac)
                    `HVPC_AC_ENABLED:    want = 1'b1;                                   // see RQ3
                    `HVPC_AC_TIMER1,
                    `HVPC_AC_TIMER2,
                    `HVPC_AC_TIMER3,
                    `HVPC_AC_TIMER4:     want = t_lvl;                                  // see RQ4
                    `HVPC_AC_DIRECT_INV: want = direct_ok & ~src_lvl;                   // see RQ14
                    `HVPC_AC_DIRECT:     want = direct_ok & src_lvl;                    // see RQ14, RQ17
                    default:             want = 1'b0;
                endcase
            end

            assign drv_on[g] = present && (cc != `HVPC_CC_OFF) && want &&
                               (is_hs || (is_ls && i_normal_mode));                     // see RQ2, RQ5

            assign sample_ev[g] = present && is_in &&
                                  (((ac == `HVPC_AC_ENABLED) && wake_tick) ||          // see RQ7
                                   (act_timer && timer_fall[tsel]));                   // see RQ6, RQ8

            always @(posedge i_clk) begin
                if (!i_rst_n) begin
                    hs_r   <= 1'b0;
                    ls_r   <= 1'b0;
                    inen_r <= 1'b0;
                    stat_r <= 1'b0;
                    rise_r <= 1'b0;
                    fall_r <= 1'b0;
                    smp_r  <= 1'b0;
                end else begin
                    hs_r   <= drv_on[g] & is_hs;
                    ls_r   <= drv_on[g] & is_ls;                                        // see RQ5
                    inen_r <= present & is_in;                                          // see RQ2
                    rise_r <= 1'b0;
                    fall_r <= 1'b0;
                    if (!is_in || (ac == `HVPC_AC_DISABLED)) begin
                        smp_r <= 1'b0;
                    end else if (sample_ev[g]) begin
                        stat_r <= level[g];                                             // see RQ10
                        smp_r  <= 1'b1;
                        // First sample after activation has nothing to compare against
                        if (smp_r) begin
                            rise_r <= i_rise_irq_en[g] & ~stat_r & level[g];            // see RQ11
                            fall_r <= i_fall_irq_en[g] & stat_r & ~level[g];            // see RQ11
                        end
                    end
                end
            end

            hvpc_slope_delay u_slope (
                .i_clk      (i_clk),
                .i_rst_n    (i_rst_n),
                .i_on       (drv_on[g]),
                .i_slope_en (slope_en[g]),
                .o_ramp     (o_slope_ramp[g]),
                .o_full     (o_full_on[g])
            );
        end
    endgenerate
endmodule

// >>> hvpc_top_sva.sv
// Assertions on the high-voltage pin control ports
`timescale 1ns/100ps
module hvpc_top_sva (
    input logic        i_clk,
    input logic        i_rst_n,
    input logic        i_eight_pins,
    input logic        i_normal_mode,
    input logic [23:0] i_pin_function_config,
    input logic [23:0] i_pin_activation_control,
    input logic        i_bank0_wake_threshold_sel,
    input logic        i_bank1_wake_threshold_sel,
    input logic [7:0]  i_level_above_gnd_thr,
    input logic [3:0]  i_timer_pulse,
    input logic [2:0]  i_limp_home_cfg,
    input logic [7:0]  i_rise_irq_en,
    input logic [7:0]  i_fall_irq_en,
    input logic [7:0]  o_hs_drive,
    input logic [7:0]  o_ls_drive,
    input logic [7:0]  o_slope_ramp,
    input logic [7:0]  o_full_on,
    input logic [7:0]  o_input_en,
    input logic [7:0]  o_pin_wake_level_status,
    input logic [7:0]  o_rising_edge_wake_irq,
    input logic [7:0]  o_falling_edge_wake_irq
);
    wire [2:0] cc0 = i_pin_function_config[2:0];
    wire [2:0] ac0 = i_pin_activation_control[2:0];
    wire       gt  = !i_bank0_wake_threshold_sel && !i_bank1_wake_threshold_sel;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_off; cc0 == 3'h0 |=> !o_hs_drive[0] && !o_ls_drive[0] && !o_input_en[0]; endproperty
    a_off: assert property (p_off) else $error("unconfigured pin active");
    property p_on; cc0 == 3'h1 && ac0 == 3'h1 |=> o_hs_drive[0] && o_full_on[0] && !o_slope_ramp[0]; endproperty
    a_on: assert property (p_on) else $error("enabled driver off");
    property p_tmr; cc0 == 3'h1 && ac0 == 3'h2 |=> o_hs_drive[0] == $past(i_timer_pulse[0]); endproperty
    a_tmr: assert property (p_tmr) else $error("driver not following timer");
    property p_ls; !i_normal_mode |=> o_ls_drive == 8'h00; endproperty
    a_ls: assert property (p_ls) else $error("low side on outside normal");
    property p_bank; !i_eight_pins |=> o_hs_drive[7:4] == 4'h0 && o_ls_drive[7:4] == 4'h0; endproperty
    a_bank: assert property (p_bank) else $error("absent bank driven");
    property p_dir; i_eight_pins && gt && cc0 == 3'h1 && ac0[2:1] == 2'b11 && i_pin_function_config[14:12] == 3'h5
        |=> o_hs_drive[0] == ($past(i_level_above_gnd_thr[4]) ^ !$past(ac0[0])); endproperty
    a_dir: assert property (p_dir) else $error("direct pair mismatch");
    property p_limp; i_limp_home_cfg[0] && i_pin_activation_control[5:4] == 2'b11 |=> !o_hs_drive[1]; endproperty
    a_limp: assert property (p_limp) else $error("direct control on limp pin");
    property p_nosmp; cc0 == 3'h5 && ac0 == 3'h0 |=> $stable(o_pin_wake_level_status[0]); endproperty
    a_nosmp: assert property (p_nosmp) else $error("disabled input sampled");
    property p_smp; gt && cc0 == 3'h5 && ac0 == 3'h2 && $fell(i_timer_pulse[0])
        |=> o_pin_wake_level_status[0] == $past(i_level_above_gnd_thr[0]); endproperty
    a_smp: assert property (p_smp) else $error("timer sample wrong");
    property p_irq; o_rising_edge_wake_irq[0] |-> $rose(o_pin_wake_level_status[0]) && $past(i_rise_irq_en[0]); endproperty
    a_irq: assert property (p_irq) else $error("rising irq without cause");
    property p_firq; o_falling_edge_wake_irq[0]
        |-> $fell(o_pin_wake_level_status[0]) && $past(i_fall_irq_en[0]); endproperty
    a_firq: assert property (p_firq) else $error("falling irq without cause");
    property p_slope; $rose(o_slope_ramp[0]) |-> !o_full_on[0] [*8]; endproperty
    a_slope: assert property (p_slope) else $error("full on during ramp");
endmodule
bind hvpc_top hvpc_top_sva u_sva (.*);

// >>> hvpc_pins_model.sv
// Switches and bank supplies seen by the pin comparators
`timescale 1ns/100ps
module hvpc_pins_model (
    input  wire logic [7:0] i_switch_closed,
    input  wire logic [1:0] i_supply_ok,
    output logic      [7:0] o_above_gnd,
    output logic      [7:0] o_above_ratio
);
    // Closed switch pulls the pin to its bank supply
    assign o_above_gnd   = i_switch_closed;
    // Ratio level also needs the bank supply in range
    assign o_above_ratio = i_switch_closed & {{4{i_supply_ok[1]}}, {4{i_supply_ok[0]}}};
endmodule

// >>> tb_hvpc_top.sv
// Self-checking testbench for the high-voltage pin control block
`timescale 1ns/100ps
module tb_hvpc_top;
    logic        clk, rst_n, eight, normal, sel0, sel1, clr;
    logic [23:0] fc, ac;
    logic [7:0]  sw, ren, fen, gnd, rat, hs, ls, ramp, full, inen, st, rirq, firq, rs, fs;
    logic [3:0]  tp;
    logic [2:0]  limp;
    logic [1:0]  sup;
    integer      errors, checks_done, t;
    hvpc_pins_model pins (.i_switch_closed(sw), .i_supply_ok(sup), .o_above_gnd(gnd), .o_above_ratio(rat));
    hvpc_top #(.WAKE_CYC(8)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_eight_pins(eight), .i_normal_mode(normal),
        .i_pin_function_config(fc), .i_pin_activation_control(ac), .i_bank0_wake_threshold_sel(sel0),
        .i_bank1_wake_threshold_sel(sel1), .i_level_above_gnd_thr(gnd), .i_level_above_ratio_thr(rat),
        .i_timer_pulse(tp), .i_limp_home_cfg(limp), .i_rise_irq_en(ren), .i_fall_irq_en(fen),
        .o_hs_drive(hs), .o_ls_drive(ls), .o_slope_ramp(ramp), .o_full_on(full), .o_input_en(inen),
        .o_pin_wake_level_status(st), .o_rising_edge_wake_irq(rirq), .o_falling_edge_wake_irq(firq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Sticky record of interrupt pulses
    always @(posedge clk) begin
        if (!rst_n || clr) begin
            rs <= 8'h00;
            fs <= 8'h00;
        end else begin
            rs <= rs | rirq;
            fs <= fs | firq;
        end
    end
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task pin(input integer k, input [2:0] c, input [2:0] a);
        begin
            fc[3*k +: 3] = c;
            ac[3*k +: 3] = a;
        end
    endtask
    // Timer pulse of two cycles, then time for the sample to land
    task pulse(input integer n);
        begin
            clr = 1'b1;
            tp[n] = 1'b1;
            cyc(1);
            clr = 1'b0;
            cyc(1);
            tp[n] = 1'b0;
            cyc(3);
        end
    endtask
    initial begin
        #(3000 * 100);
        errors = errors + 1;
        report_and_stop;
    end
    initial begin
        {errors, checks_done, rst_n, normal, sel0, sel1, fc, ac, tp, limp, sw, clr} = 0;
        {eight, sup, ren, fen} = 19'h7ffff;
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        chk(hs | ls | inen, 8'h00);
        pin(0, 3'h0, 3'h1);
        cyc(2);
        chk(hs | inen, 8'h00);
        pin(0, 3'h1, 3'h1);
        cyc(2);
        chk({full[0], ramp[0], hs}, 10'h201);
        pin(0, 3'h3, 3'h1);
        cyc(2);
        chk(ls, 8'h00);
        normal = 1'b1;
        cyc(2);
        chk(ls, 8'h01);
        for (t = 0; t < 4; t = t + 1) begin
            pin(0, 3'h1, 3'h2 + t[2:0]);
            tp = 4'h1 << t;
            cyc(2);
            chk(hs, 8'h01);
            tp = 4'h1 << ((t + 1) % 4);
            cyc(2);
            chk(hs, 8'h00);
        end
        tp = 4'h0;
        pin(0, 3'h0, 3'h0);
        cyc(2);
        pin(0, 3'h2, 3'h1);
        cyc(2);
        chk({ramp[0], full[0]}, 8'h02);
        cyc(110);
        chk(full, 8'h01);
        $display("drive test done");
        pin(0, 3'h1, 3'h7);
        pin(4, 3'h5, 3'h0);
        sw = 8'h10;
        cyc(2);
        chk(hs, 8'h01);
        sw = 8'h00;
        cyc(2);
        chk(hs, 8'h00);
        pin(0, 3'h1, 3'h6);
        pin(1, 3'h1, 3'h7);
        cyc(2);
        chk(hs, 8'h01);
        pin(5, 3'h5, 3'h0);
        sw = 8'h20;
        limp = 3'h1;
        cyc(2);
        chk(hs, 8'h01);
        limp = 3'h0;
        cyc(2);
        chk(hs, 8'h03);
        sel1 = 1'b1;
        sup = 2'b01;
        cyc(2);
        chk(hs, 8'h01);
        sel1 = 1'b0;
        sup = 2'b11;
        pin(4, 3'h1, 3'h1);
        eight = 1'b0;
        cyc(2);
        chk(hs, 8'h00);
        eight = 1'b1;
        cyc(2);
        chk(hs, 8'h12);
        $display("direct test done");
        fc = 24'h0;
        ac = 24'h0;
        pin(0, 3'h5, 3'h2);
        sw = 8'h01;
        pulse(0);
        chk({rs[0], fs[0], st}, 10'h001);
        chk(inen, 8'h01);
        sw = 8'h00;
        cyc(5);
        chk(st, 8'h01);
        pulse(0);
        chk({rs[0], fs[0], st}, 10'h100);
        sw = 8'h01;
        pulse(0);
        chk({rs[0], fs[0], st}, 10'h201);
        fen = 8'h00;
        sw = 8'h00;
        pulse(0);
        chk({rs[0], fs[0], st}, 10'h000);
        ren = 8'h00;
        sw = 8'h01;
        pulse(0);
        chk({rs[0], fs[0], st}, 10'h001);
        sel0 = 1'b1;
        sup = 2'b10;
        pulse(0);
        chk(st, 8'h00);
        sup = 2'b11;
        pulse(0);
        chk(st, 8'h01);
        sel0 = 1'b0;
        $display("wake timer test done");
        pin(0, 3'h5, 3'h0);
        sw = 8'h00;
        cyc(20);
        chk(st, 8'h01);
        pin(0, 3'h5, 3'h1);
        cyc(20);
        chk(st, 8'h00);
        sw = 8'h01;
        cyc(20);
        chk(st, 8'h01);
        $display("wake sampling test done");
        report_and_stop;
    end
endmodule
